// ===== rtl/bsp_pkg.sv
// shared constants for the burst sram port
package bsp_pkg;
    localparam int BSP_DW = 36;
    localparam int BSP_AW = 17;
    localparam int BSP_LANES = 4;
    localparam int BSP_LANE_W = 9;
    localparam int BSP_BURST = 4;
    localparam int BSP_MEM_WORDS = BSP_BURST << BSP_AW;
    localparam logic [7:0] BSP_REG_CTRL = 8'h00;
    localparam logic [7:0] BSP_REG_STATUS = 8'h04;
    localparam logic [7:0] BSP_REG_RDCNT = 8'h08;
    localparam logic [7:0] BSP_REG_WRCNT = 8'h0c;
    localparam int BSP_CTRL_WPROT_BIT = 0;
    localparam int BSP_STAT_PLL_BIT = 0;
    localparam logic BSP_CTRL_RESET = 1'b0;
    localparam logic [31:0] BSP_CNT_RESET = 32'h0000_0000;
    localparam logic [31:0] BSP_UNMAPPED_DATA = 32'h0000_0000;
    localparam logic [1:0] BSP_WORD0 = 2'h0;
    localparam logic [1:0] BSP_WORD1 = 2'h1;
    localparam logic [1:0] BSP_WORD2 = 2'h2;
    localparam logic [1:0] BSP_WORD3 = 2'h3;
    typedef enum {BSP_LAT_LEGACY, BSP_LAT_EXTENDED} bsp_lat_t;
endpackage

// ===== rtl/bsp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module bsp_sync
(
    input wire logic clk_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_r;
    logic hold_r;

    // first stage feeds only the second
    always_ff @(posedge clk_i)
    begin
        meta_r <= d_i;
        hold_r <= meta_r;
    end

    assign q_o = hold_r;
endmodule
`default_nettype wire

// ===== rtl/bsp_port.sv
// burst sram port: ddr link on k clock, wishbone control and statistics
//
// Summary of operation
// - lane write selects are sampled on both clock edges with their data word
// - a byte whose lane select is high is not written
// - lane n governs data bits 9n+8 down to 9n
// - one shared address bus, sampled on true clock rise for active ports
// - address ignored on an edge where that port is deselected
// - four arrays, one per burst word; 17 address bits for 36-bit words
// - read words are launched on both true and complementary rising edges
// - read select low at true clock rise starts a read; high deselects
// - after deselect, pending read completes, then outputs float at next rise
// - each read delivers four sequential words of the addressed location
// - valid indicator marks valid read data, aligned with echo clocks
// - accesses begin on true clock rise, which captures and launches
// - complementary rise also captures inputs and launches read data
// - two free-running echo clocks follow true and complementary clocks
// - write select low at true clock rise starts a write; high ignores data
// - pll bypass low selects one-cycle latency instead of 2.5 cycles
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module bsp_port
    import bsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic k_clk_i,
    input wire logic [BSP_AW-1:0] address_i,
    input wire logic read_port_select_n_i,
    input wire logic write_port_select_n_i,
    input wire logic [BSP_LANES-1:0] byte_lane_write_select_n_i,
    input wire logic [BSP_DW-1:0] data_i,
    input wire logic pll_bypass_n_i,
    output logic [BSP_DW-1:0] data_o,
    output logic data_oe_n_o,
    output logic output_valid_indicator_o,
    output logic echo_timing_output_o,
    output logic echo_timing_output_n_o
);
    function automatic logic [BSP_AW+1:0] word_index(input logic [BSP_AW-1:0] a,
                                                     input logic [1:0] w);
        word_index = {a, w};
    endfunction

    // lane n covers bits 9n+8:9n; deselected lanes keep the stored byte
    function automatic logic [BSP_DW-1:0] lane_merge(input logic [BSP_DW-1:0] old_w,
                                                     input logic [BSP_DW-1:0] new_w,
                                                     input logic [BSP_LANES-1:0] sel_n);
        logic [BSP_DW-1:0] r;
        r = old_w;
        for (int i = 0; i < BSP_LANES; i++)
        begin
            if (!sel_n[i])
            begin
                r[i*BSP_LANE_W +: BSP_LANE_W] = new_w[i*BSP_LANE_W +: BSP_LANE_W];
            end
        end
        lane_merge = r;
    endfunction

    // four arrays of one word position each, flattened as {address, word}
    logic [BSP_DW-1:0] mem_r [0:BSP_MEM_WORDS-1];

    logic krst, wprot_k, pll_k, pll_c;
    logic rd_tog_c, wr_tog_c, ctrl_wprot_r;
    bsp_sync u_sync_rst
    (
        .clk_i(k_clk_i),
        .d_i(rst_i),
        .q_o(krst)
    );
    bsp_sync u_sync_wprot
    (
        .clk_i(k_clk_i),
        .d_i(ctrl_wprot_r),
        .q_o(wprot_k)
    );
    // the bypass pin is static in practice; synchronise it anyway
    bsp_sync u_sync_pll_k
    (
        .clk_i(k_clk_i),
        .d_i(pll_bypass_n_i),
        .q_o(pll_k)
    );
    bsp_sync u_sync_pll_c
    (
        .clk_i(clk_i),
        .d_i(pll_bypass_n_i),
        .q_o(pll_c)
    );

    // ---------------- link domain, true clock rise ----------------
    bsp_lat_t lat_mode;
    logic [4:1] rv_r;
    logic [2:1] wv_r;
    logic [BSP_AW-1:0] ra_r [1:4];
    logic [BSP_AW-1:0] wa_r [1:2];
    logic rd_acc, wr_acc, rd_tog_r, wr_tog_r;
    logic q_pos_v_r, q_neg_prep_v_r, q_neg_v_r, oe_n_r, echo_pos_r, echo_neg_r;
    logic [BSP_DW-1:0] q_pos_r, q_neg_prep_r, q_neg_r, wd_neg_r;
    logic [BSP_LANES-1:0] wb_neg_r;
    assign lat_mode = pll_k ? BSP_LAT_EXTENDED : BSP_LAT_LEGACY;

    // a burst spans two true clock cycles, so the edge after an accept is not a request
    assign rd_acc = !read_port_select_n_i && !rv_r[1];
    assign wr_acc = !write_port_select_n_i && !wv_r[1];

    // request pipelines; address held only for selected ports
    always_ff @(posedge k_clk_i)
    begin
        if (krst)
        begin
            rv_r <= 4'h0;
            wv_r <= 2'h0;
        end
        else
        begin
            rv_r <= {rv_r[3:1], rd_acc};
            wv_r <= {wv_r[1], wr_acc};
        end
        if (rd_acc)
        begin
            ra_r[1] <= address_i;
        end
        ra_r[2] <= ra_r[1];
        ra_r[3] <= ra_r[2];
        ra_r[4] <= ra_r[3];
        if (wr_acc)
        begin
            wa_r[1] <= address_i;
        end
        wa_r[2] <= wa_r[1];
    end

    // event toggles for the statistics counters
    always_ff @(posedge k_clk_i)
    begin
        if (krst)
        begin
            rd_tog_r <= 1'b0;
            wr_tog_r <= 1'b0;
        end
        else
        begin
            rd_tog_r <= rd_tog_r ^ rd_acc;
            wr_tog_r <= wr_tog_r ^ wr_acc;
        end
    end

    // memory writes: even word from the complementary capture, odd word from this edge
    always_ff @(posedge k_clk_i)
    begin
        if (!krst && !wprot_k)
        begin
            if (wv_r[1])
            begin
                mem_r[word_index(wa_r[1], BSP_WORD0)] <= lane_merge(
                    mem_r[word_index(wa_r[1], BSP_WORD0)], wd_neg_r, wb_neg_r);
                mem_r[word_index(wa_r[1], BSP_WORD1)] <= lane_merge(
                    mem_r[word_index(wa_r[1], BSP_WORD1)], data_i,
                    byte_lane_write_select_n_i);
            end
            if (wv_r[2])
            begin
                mem_r[word_index(wa_r[2], BSP_WORD2)] <= lane_merge(
                    mem_r[word_index(wa_r[2], BSP_WORD2)], wd_neg_r, wb_neg_r);
                mem_r[word_index(wa_r[2], BSP_WORD3)] <= lane_merge(
                    mem_r[word_index(wa_r[2], BSP_WORD3)], data_i,
                    byte_lane_write_select_n_i);
            end
        end
    end

    // read launch schedule: legacy starts one cycle on, extended 2.5 cycles on
    always_ff @(posedge k_clk_i)
    begin
        if (krst)
        begin
            q_pos_v_r <= 1'b0;
            q_neg_prep_v_r <= 1'b0;
            q_pos_r <= '0;
            q_neg_prep_r <= '0;
        end
        else
        begin
            q_pos_v_r <= 1'b0;
            q_neg_prep_v_r <= 1'b0;
            case (lat_mode)
                BSP_LAT_LEGACY:
                begin
                    if (rv_r[1])
                    begin
                        q_pos_v_r <= 1'b1;
                        q_pos_r <= mem_r[word_index(ra_r[1], BSP_WORD0)];
                        q_neg_prep_v_r <= 1'b1;
                        q_neg_prep_r <= mem_r[word_index(ra_r[1], BSP_WORD1)];
                    end
                    if (rv_r[2])
                    begin
                        q_pos_v_r <= 1'b1;
                        q_pos_r <= mem_r[word_index(ra_r[2], BSP_WORD2)];
                        q_neg_prep_v_r <= 1'b1;
                        q_neg_prep_r <= mem_r[word_index(ra_r[2], BSP_WORD3)];
                    end
                end
                BSP_LAT_EXTENDED:
                begin
                    if (rv_r[2])
                    begin
                        q_neg_prep_v_r <= 1'b1;
                        q_neg_prep_r <= mem_r[word_index(ra_r[2], BSP_WORD0)];
                    end
                    if (rv_r[3])
                    begin
                        q_pos_v_r <= 1'b1;
                        q_pos_r <= mem_r[word_index(ra_r[3], BSP_WORD1)];
                        q_neg_prep_v_r <= 1'b1;
                        q_neg_prep_r <= mem_r[word_index(ra_r[3], BSP_WORD2)];
                    end
                    if (rv_r[4])
                    begin
                        q_pos_v_r <= 1'b1;
                        q_pos_r <= mem_r[word_index(ra_r[4], BSP_WORD3)];
                    end
                end
                default: q_pos_v_r <= 1'b0;
            endcase
        end
    end

    // drivers stay on while a pending burst still has words, off at the next rise
    always_ff @(posedge k_clk_i)
    begin
        if (krst)
        begin
            oe_n_r <= 1'b1;
        end
        else
        begin
            oe_n_r <= (lat_mode == BSP_LAT_LEGACY) ? !(rv_r[1] || rv_r[2])
                : !(rv_r[2] || rv_r[3] || rv_r[4]);
        end
    end
    // echo clock half driven on the true rise, runs regardless of traffic
    always_ff @(posedge k_clk_i)
    begin
        if (krst)
        begin
            echo_pos_r <= 1'b0;
        end
        else
        begin
            echo_pos_r <= !echo_pos_r;
        end
    end

    // ---------------- link domain, complementary clock rise ----------------
    always_ff @(negedge k_clk_i)
    begin
        wd_neg_r <= data_i;
        wb_neg_r <= byte_lane_write_select_n_i;
        q_neg_r <= q_neg_prep_r;
        q_neg_v_r <= q_neg_prep_v_r && !krst;
        echo_neg_r <= echo_pos_r;
    end
    // ddr output: the clock level picks the half launched by the last edge
    assign data_o = k_clk_i ? q_pos_r : q_neg_r;
    assign output_valid_indicator_o = k_clk_i ? q_pos_v_r : q_neg_v_r;
    assign data_oe_n_o = oe_n_r;
    // toggles equal after each complementary rise, differ after each true rise
    assign echo_timing_output_o = echo_pos_r ^ echo_neg_r;
    assign echo_timing_output_n_o = !(echo_pos_r ^ echo_neg_r);

    // ---------------- system domain: wishbone slave ----------------
    bsp_sync u_sync_rd
    (
        .clk_i(clk_i),
        .d_i(rd_tog_r),
        .q_o(rd_tog_c)
    );
    bsp_sync u_sync_wr
    (
        .clk_i(clk_i),
        .d_i(wr_tog_r),
        .q_o(wr_tog_c)
    );

    logic rd_tog_d_r, wr_tog_d_r, wb_req;
    logic [31:0] rd_cnt_r, wr_cnt_r, rd_nxt;
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // bursts counted per request; counts lag the link by a few system clocks
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_tog_d_r <= 1'b0;
            wr_tog_d_r <= 1'b0;
            rd_cnt_r <= BSP_CNT_RESET;
            wr_cnt_r <= BSP_CNT_RESET;
        end
        else
        begin
            rd_tog_d_r <= rd_tog_c;
            wr_tog_d_r <= wr_tog_c;
            if (rd_tog_c != rd_tog_d_r)
            begin
                rd_cnt_r <= rd_cnt_r + 32'h1;
            end
            if (wr_tog_c != wr_tog_d_r)
            begin
                wr_cnt_r <= wr_cnt_r + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_wprot_r <= BSP_CTRL_RESET;
        end
        // lands on the edge at which the master sees ack, while its request still stands
        else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == BSP_REG_CTRL)
        begin
            ctrl_wprot_r <= wb_dat_i[BSP_CTRL_WPROT_BIT];
        end
    end

    always_comb
    begin
        rd_nxt = BSP_UNMAPPED_DATA;
        case (wb_adr_i)
            BSP_REG_CTRL: rd_nxt[BSP_CTRL_WPROT_BIT] = ctrl_wprot_r;
            BSP_REG_STATUS: rd_nxt[BSP_STAT_PLL_BIT] = pll_c;
            BSP_REG_RDCNT: rd_nxt = rd_cnt_r;
            BSP_REG_WRCNT: rd_nxt = wr_cnt_r;
            default: rd_nxt = BSP_UNMAPPED_DATA;
        endcase
    end

    // one wait state; unmapped addresses still ack and read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= BSP_UNMAPPED_DATA;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i)
            begin
                wb_dat_o <= rd_nxt;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/bsp_port_props.sv
// concurrent checks on the burst sram port pins
`timescale 1ns/1ps
`default_nettype none
module bsp_port_props
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic k_clk_i,
    input wire logic read_port_select_n_i,
    input wire logic pll_bypass_n_i,
    input wire logic data_oe_n_o,
    input wire logic output_valid_indicator_o,
    input wire logic echo_timing_output_o,
    input wire logic echo_timing_output_n_o
);
    logic [3:0] up_r;
    logic [3:0] idle_r;
    logic acc_r;
    logic rd_acc;
    // the rise right after an accepted read is no request
    assign rd_acc = (up_r >= 4'h2) && !read_port_select_n_i && !acc_r;
    // k-side reset is resynchronised, so checks wait a few rises
    always_ff @(posedge k_clk_i)
    begin
        if (rst_i)
        begin
            up_r <= 4'h0;
            idle_r <= 4'hf;
            acc_r <= 1'b0;
        end
        else
        begin
            up_r <= (up_r == 4'hf) ? up_r : up_r + 4'h1;
            idle_r <= rd_acc ? 4'h0 : ((idle_r == 4'hf) ? idle_r : idle_r + 4'h1);
            acc_r <= rd_acc;
        end
    end
    wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> $past(wb_cyc_i) && !$past(wb_ack_o)) else $error("stray ack");
    legacy_rise_a: assert property (@(posedge k_clk_i) disable iff (rst_i)
        rd_acc && !pll_bypass_n_i |-> ##2 (output_valid_indicator_o && !data_oe_n_o) [*2])
        else $error("legacy odd words missing");
    legacy_fall_a: assert property (@(negedge k_clk_i) disable iff (rst_i)
        acc_r && !pll_bypass_n_i |-> ##1 output_valid_indicator_o ##1 output_valid_indicator_o)
        else $error("legacy even words missing");
    ext_rise_a: assert property (@(posedge k_clk_i) disable iff (rst_i)
        rd_acc && pll_bypass_n_i |-> ##3 (output_valid_indicator_o && !data_oe_n_o) [*2])
        else $error("extended words missing");
    idle_float_a: assert property (@(posedge k_clk_i) disable iff (rst_i)
        up_r >= 4'h6 && idle_r >= 4'h6 |-> data_oe_n_o && !output_valid_indicator_o)
        else $error("outputs driven while idle");
    echo_low_a: assert property (@(posedge k_clk_i) disable iff (rst_i)
        up_r >= 4'h6 |-> !echo_timing_output_o && echo_timing_output_n_o)
        else $error("echo wrong in low phase");
    echo_high_a: assert property (@(negedge k_clk_i) disable iff (rst_i)
        up_r >= 4'h6 |-> echo_timing_output_o && !echo_timing_output_n_o)
        else $error("echo wrong in high phase");
endmodule
bind bsp_port bsp_port_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .k_clk_i(k_clk_i),
    .read_port_select_n_i(read_port_select_n_i), .pll_bypass_n_i(pll_bypass_n_i),
    .data_oe_n_o(data_oe_n_o), .output_valid_indicator_o(output_valid_indicator_o),
    .echo_timing_output_o(echo_timing_output_o),
    .echo_timing_output_n_o(echo_timing_output_n_o));
`default_nettype wire

// ===== tb/bsp_ctl_model.sv
// memory controller model on the link side of the port
`timescale 1ns/1ps
`default_nettype none
module bsp_ctl_model
    import bsp_pkg::*;
(
    input wire logic k_clk_i,
    input wire logic [BSP_DW-1:0] q_i,
    input wire logic valid_i,
    output logic [BSP_AW-1:0] address_o,
    output logic read_port_select_n_o,
    output logic write_port_select_n_o,
    output logic [BSP_LANES-1:0] byte_lane_write_select_n_o,
    output logic [BSP_DW-1:0] data_o
);
    logic [BSP_DW-1:0] rd_q[$];
    initial
    begin
        address_o = '0;
        read_port_select_n_o = 1'b1;
        write_port_select_n_o = 1'b1;
        byte_lane_write_select_n_o = 4'hf;
        data_o = '0;
    end
    // capture 20 ns into each half-period, clear of the launching edge
    always @(k_clk_i)
    begin
        #20;
        if (valid_i === 1'b1)
            rd_q.push_back(q_i);
    end
    // one port at a time, so read and write never share a rise
    task automatic write_burst(input logic [BSP_AW-1:0] a, input logic [BSP_DW-1:0] d[4],
                               input logic [BSP_LANES-1:0] m[4]);
        @(negedge k_clk_i);
        write_port_select_n_o <= 1'b0;
        address_o <= a;
        for (int i = 0; i < 4; i++)
        begin
            if (i % 2 == 0)
                @(posedge k_clk_i);
            else
                @(negedge k_clk_i);
            data_o <= d[i];
            byte_lane_write_select_n_o <= m[i];
            write_port_select_n_o <= 1'b1;
            address_o <= ~a;
        end
        @(posedge k_clk_i);
        // released lines carry junk, never the last value
        data_o <= ~d[3];
        byte_lane_write_select_n_o <= ~m[3];
    endtask
    task automatic read_burst(input logic [BSP_AW-1:0] a);
        rd_q.delete();
        @(negedge k_clk_i);
        read_port_select_n_o <= 1'b0;
        address_o <= a;
        @(posedge k_clk_i);
        read_port_select_n_o <= 1'b1;
        address_o <= ~a;
        repeat (6) @(posedge k_clk_i);
    endtask
endmodule
`default_nettype wire

// ===== tb/bsp_port_tb.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
`default_nettype none
module bsp_port_tb
    import bsp_pkg::*;
;
    localparam logic [BSP_AW-1:0] A_HI = 17'h1ffff;
    localparam logic [BSP_AW-1:0] A_LO = 17'h00000;
    logic clk_i = 1'b0;
    logic k_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, pll_bypass_n_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic wb_ack_o, oe_n, vld, echo, echo_n, rsel_n, wsel_n;
    logic [BSP_AW-1:0] addr;
    logic [BSP_LANES-1:0] lanes_n;
    logic [BSP_DW-1:0] din, dout;
    logic [BSP_DW-1:0] exp_m[2][4], wd[4], wn[4];
    logic [BSP_LANES-1:0] mf[4], ml[4];
    int bad_count = 0, tests_run = 0, cycles = 0;
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end
    initial
    begin
        #17;
        forever #62.5 k_clk_i = ~k_clk_i;
    end
    bsp_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .k_clk_i(k_clk_i), .address_i(addr),
        .read_port_select_n_i(rsel_n), .write_port_select_n_i(wsel_n),
        .byte_lane_write_select_n_i(lanes_n), .data_i(din), .pll_bypass_n_i(pll_bypass_n_i),
        .data_o(dout), .data_oe_n_o(oe_n), .output_valid_indicator_o(vld),
        .echo_timing_output_o(echo), .echo_timing_output_n_o(echo_n));
    bsp_ctl_model ctl (.k_clk_i(k_clk_i), .q_i(dout), .valid_i(vld), .address_o(addr),
        .read_port_select_n_o(rsel_n), .write_port_select_n_o(wsel_n),
        .byte_lane_write_select_n_o(lanes_n), .data_o(din));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [BSP_DW-1:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wdat;
        @(posedge clk_i);
        // ack ends this wait; if no ack ever comes, only the bench timeout ends it
        while (wb_ack_o !== 1'b1)
        begin
            @(posedge clk_i);
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic reg_chk(input logic [7:0] adr, input logic [31:0] e);
        wb_xfer(1'b0, adr, 32'h0);
        check("register", BSP_DW'(e), BSP_DW'(rdat));
    endtask
    function automatic logic [BSP_DW-1:0] merge(input logic [BSP_DW-1:0] o, n,
                                                 input logic [BSP_LANES-1:0] m);
        logic [BSP_DW-1:0] r;
        r = o;
        for (int l = 0; l < BSP_LANES; l++)
            if (!m[l])
                r[l*BSP_LANE_W +: BSP_LANE_W] = n[l*BSP_LANE_W +: BSP_LANE_W];
        return r;
    endfunction
    task automatic link_write(input int s, input logic [BSP_DW-1:0] d[4],
                              input logic [BSP_LANES-1:0] m[4], input bit keep);
        ctl.write_burst(s ? A_HI : A_LO, d, m);
        for (int i = 0; i < 4; i++)
            if (!keep)
                exp_m[s][i] = merge(exp_m[s][i], d[i], m[i]);
        repeat (2) @(posedge k_clk_i);
    endtask
    task automatic burst_chk(input int s);
        ctl.read_burst(s ? A_HI : A_LO);
        check("burst length", 36'h4, BSP_DW'(ctl.rd_q.size()));
        for (int i = 0; i < ctl.rd_q.size() && i < 4; i++)
            check("read word", exp_m[s][i], ctl.rd_q[i]);
    endtask
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            wd[i] = 36'h9a5c30f00 + 36'(i);
            wn[i] = ~wd[i];
            mf[i] = 4'h0;
            ml[i] = 4'hf ^ (4'h1 << i);
        end
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge k_clk_i);
        reg_chk(BSP_REG_CTRL, 32'(BSP_CTRL_RESET));
        reg_chk(BSP_REG_STATUS, 32'h0);
        reg_chk(BSP_REG_RDCNT, BSP_CNT_RESET);
        reg_chk(BSP_REG_WRCNT, BSP_CNT_RESET);
        reg_chk(8'h10, BSP_UNMAPPED_DATA);
        link_write(1, wd, mf, 1'b0);
        link_write(0, wn, mf, 1'b0);
        burst_chk(1);
        burst_chk(0);
        link_write(1, wn, ml, 1'b0);
        burst_chk(1);
        reg_chk(BSP_REG_RDCNT, 32'h3);
        reg_chk(BSP_REG_WRCNT, 32'h3);
        // latency mode only moves while the link is idle
        pll_bypass_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        reg_chk(BSP_REG_STATUS, 32'h1);
        burst_chk(0);
        wb_xfer(1'b1, BSP_REG_CTRL, 32'h1);
        reg_chk(BSP_REG_CTRL, 32'h1);
        // protection reaches the link clock only after its two-flop crossing
        repeat (3) @(posedge k_clk_i);
        link_write(0, wd, mf, 1'b1);
        burst_chk(0);
        wb_xfer(1'b1, BSP_REG_CTRL, 32'h0);
        reg_chk(BSP_REG_CTRL, 32'h0);
        reg_chk(BSP_REG_RDCNT, 32'h5);
        tally_and_finish();
    end
endmodule
`default_nettype wire
